// ### hw/cle_defs.svh
/*
  Constants for the character display instruction engine.
  Assumes a 125 MHz system clock; times are in nanoseconds.
*/
// What this block does
// - Clear writes space to all display RAM, zeroes counter, sets increment.
// - Return home zeroes counter and cancels display shift, RAM kept.
// - Entry direction steps counter up or down by one per RAM access.
// - Auto-shift moves display only on display RAM writes, per direction.
// - Display control sets display, cursor and blink enables; data kept.
// - Blink alternates the cursor cell between all lit and its character.
// - Shift moves cursor with counter step, or display with counter kept.
// - In two-line mode the cursor passes from position 40 to line two.
// - Display shift applies to every line, each rotating in its range.
// - Bus width bit picks 8-bit bus or 4-bit bus with two transfers.
// - Line and font bits pick 1/8, 1/11 or 1/16 duty format.
// - Pattern address instruction loads 6 bits and selects pattern RAM.
// - Display address instruction loads 7 bits and selects display RAM.
// - Display addresses are 00H-4FH, or 00H-27H and 40H-67H.
// - Data write stores the byte in the selected RAM, 37 us.
// - Data read returns a byte from the selected RAM, 37 us.
// - Codes with high nibble zero use pattern RAM, bit 3 ignored.
// - Pattern bit one lights its pixel, zero leaves it dark.
// - At power-on the device clears and loads defaults while busy.
// - Read without prior address set gives one invalid first value.
// - Counter holds RAM address and steps by one per access.
`ifndef CLE_DEFS_SVH
`define CLE_DEFS_SVH
`define CLE_CLK_NS 8
`define CLE_T_SHORT_NS 37000
`define CLE_T_LONG_NS 1520000
`define CLE_T_POR_NS 40000000
`define CLE_T_BLINK_NS 400000000
`define CLE_SPACE 8'h20
`define CLE_DD_CELLS 80
`define CLE_CG_CELLS 64
`define CLE_LINE_LEN 7'h28
`define CLE_ONE_LAST 7'h4F
`define CLE_L1_LAST 7'h27
`define CLE_L2_FIRST 7'h40
`define CLE_L2_LAST 7'h67
`define CLE_CFG_RST 8'h82
`define CLE_DUTY_8 2'h0
`define CLE_DUTY_11 2'h1
`define CLE_DUTY_16 2'h2
`define CLE_B_DD 7
`define CLE_B_CG 6
`define CLE_B_FN 5
`define CLE_B_SH 4
`define CLE_B_DC 3
`define CLE_B_EM 2
`define CLE_B_HM 1
`define CLE_B_CL 0
`define CLE_B_DL 4
`define CLE_B_N 3
`define CLE_B_F 2
`define CLE_B_D 2
`define CLE_B_C 1
`define CLE_B_B 0
`define CLE_B_SC 3
`define CLE_B_RL 2
`define CLE_B_ID 1
`define CLE_B_S 0
`endif

// ### hw/cle_pkg.sv
/*
  Types for the character display instruction engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cle_pkg;
  typedef enum {
    CLE_CMD_NONE, CLE_CMD_CLEAR, CLE_CMD_HOME, CLE_CMD_ENTRY,
    CLE_CMD_DISP, CLE_CMD_SHIFT, CLE_CMD_FUNC, CLE_CMD_CGADDR,
    CLE_CMD_DDADDR, CLE_CMD_WRDATA, CLE_CMD_RDDATA, CLE_CMD_STATUS
  } cle_cmd_e;
  typedef enum {CLE_ST_IDLE, CLE_ST_EXEC} cle_state_e;
  typedef struct packed {
    logic bus8;
    logic two_line;
    logic font;
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic inc;
    logic auto_shift;
  } cle_cfg_s;
  typedef struct packed {
    logic [7:0] code;
    logic from_pattern;
    logic cursor_here;
    logic [4:0] pixels;
  } cle_cell_s;
endpackage

// ### hw/cle_engine.sv
/*
  Instruction engine of a character display controller: decoder,
  address counter, display and pattern RAM, shift, busy timing.
  Assumes host strobes synchronous to i_clk_sys and a scan driver
  that asks for one cell at a time.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cle_defs.svh"
module cle_engine #(
  parameter int unsigned SHORT_CYC = (`CLE_T_SHORT_NS + `CLE_CLK_NS - 1) / `CLE_CLK_NS,
  parameter int unsigned LONG_CYC = (`CLE_T_LONG_NS + `CLE_CLK_NS - 1) / `CLE_CLK_NS,
  parameter int unsigned POR_CYC = (`CLE_T_POR_NS + `CLE_CLK_NS - 1) / `CLE_CLK_NS,
  parameter int unsigned BLINK_CYC = `CLE_T_BLINK_NS / `CLE_CLK_NS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_reg_select,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_busy_flag,
  output cle_pkg::cle_cfg_s o_cfg,
  output logic [1:0] o_duty,
  input wire logic i_scan_line,
  input wire logic [6:0] i_scan_col,
  input wire logic [3:0] i_scan_row,
  output cle_pkg::cle_cell_s o_cell
);
  import cle_pkg::*;

  logic [7:0] dram [`CLE_DD_CELLS];
  logic [7:0] pram [`CLE_CG_CELLS];
  cle_state_e state;
  cle_cmd_e cmd;
  logic [31:0] busy_cnt;
  logic [6:0] ac;
  logic [6:0] ac_new;
  logic cg_sel;
  logic [6:0] ofs;
  logic fill_on;
  logic [6:0] fill_idx;
  logic phase;
  logic [3:0] hold_nib;
  logic [3:0] lo_nib;
  logic [7:0] rd_latch;
  logic [7:0] byte_in;
  logic [7:0] rd_word;
  logic wr_done;
  logic rd_first;
  logic go;
  logic [6:0] line_len;
  logic [6:0] wr_idx;
  logic [31:0] blink_cnt;
  logic blink_ph;

  // Invalid addresses map past the array so they never alias a cell
  function automatic logic [6:0] dd_idx(input logic [6:0] a, input logic two);
    if (two) begin
      if (a[5:0] > `CLE_L1_LAST) begin
        dd_idx = 7'(`CLE_DD_CELLS);
      end else if (a[6]) begin
        dd_idx = 7'({1'b0, a[5:0]} + `CLE_LINE_LEN);
      end else begin
        dd_idx = a;
      end
    end else begin
      dd_idx = (a <= `CLE_ONE_LAST) ? a : 7'(`CLE_DD_CELLS);
    end
  endfunction

  function automatic logic [6:0] dd_step(input logic [6:0] a, input logic up, input logic two);
    if (two && up) begin
      dd_step = (a == `CLE_L1_LAST) ? `CLE_L2_FIRST :
                (a == `CLE_L2_LAST) ? 7'h00 : 7'(a + 7'h01);
    end else if (two) begin
      dd_step = (a == 7'h00) ? `CLE_L2_LAST :
                (a == `CLE_L2_FIRST) ? `CLE_L1_LAST : 7'(a - 7'h01);
    end else if (up) begin
      dd_step = (a == `CLE_ONE_LAST) ? 7'h00 : 7'(a + 7'h01);
    end else begin
      dd_step = (a == 7'h00) ? `CLE_ONE_LAST : 7'(a - 7'h01);
    end
  endfunction

  function automatic logic [7:0] dd_read(input logic [6:0] i);
    dd_read = (i < 7'(`CLE_DD_CELLS)) ? dram[i] : 8'h00;
  endfunction

  // Byte assembly: high nibble held, low nibble completes the byte
  assign byte_in = o_cfg.bus8 ? i_wdata : {hold_nib, i_wdata[7:4]};
  assign wr_done = i_wr & (o_cfg.bus8 | phase);
  assign rd_first = i_rd & (o_cfg.bus8 | ~phase);
  assign line_len = o_cfg.two_line ? `CLE_LINE_LEN : 7'(`CLE_DD_CELLS);
  assign wr_idx = dd_idx(ac, o_cfg.two_line);
  assign rd_word = i_reg_select ? rd_latch : {o_busy_flag, ac};

  always_comb begin
    cmd = CLE_CMD_NONE;
    if (i_reg_select) begin
      if (wr_done) begin
        cmd = CLE_CMD_WRDATA;
      end else if (rd_first) begin
        cmd = CLE_CMD_RDDATA;
      end
    end else if (rd_first) begin
      cmd = CLE_CMD_STATUS;
    end else if (wr_done) begin
      if (byte_in[`CLE_B_DD]) begin
        cmd = CLE_CMD_DDADDR;
      end else if (byte_in[`CLE_B_CG]) begin
        cmd = CLE_CMD_CGADDR;
      end else if (byte_in[`CLE_B_FN]) begin
        cmd = CLE_CMD_FUNC;
      end else if (byte_in[`CLE_B_SH]) begin
        cmd = CLE_CMD_SHIFT;
      end else if (byte_in[`CLE_B_DC]) begin
        cmd = CLE_CMD_DISP;
      end else if (byte_in[`CLE_B_EM]) begin
        cmd = CLE_CMD_ENTRY;
      end else if (byte_in[`CLE_B_HM]) begin
        cmd = CLE_CMD_HOME;
      end else if (byte_in[`CLE_B_CL]) begin
        cmd = CLE_CMD_CLEAR;
      end
    end
  end

  // Busy refuses every instruction but the status read
  assign go = (cmd != CLE_CMD_NONE) && (cmd != CLE_CMD_STATUS) && (state == CLE_ST_IDLE);

  always_comb begin
    ac_new = ac;
    case (cmd)
      CLE_CMD_CLEAR, CLE_CMD_HOME: begin
        ac_new = 7'h00;
      end
      CLE_CMD_DDADDR: begin
        ac_new = byte_in[6:0];
      end
      CLE_CMD_CGADDR: begin
        ac_new = {1'b0, byte_in[5:0]};
      end
      CLE_CMD_SHIFT: begin
        if (!byte_in[`CLE_B_SC]) begin
          ac_new = dd_step(ac, byte_in[`CLE_B_RL], o_cfg.two_line);
        end
      end
      CLE_CMD_WRDATA, CLE_CMD_RDDATA: begin
        if (cg_sel) begin
          ac_new = {1'b0, o_cfg.inc ? 6'(ac[5:0] + 6'h01) : 6'(ac[5:0] - 6'h01)};
        end else begin
          ac_new = dd_step(ac, o_cfg.inc, o_cfg.two_line);
        end
      end
      default: begin
      end
    endcase
  end

  // Busy timer; the reset itself stands for the power-on initialisation
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= CLE_ST_EXEC;
      busy_cnt <= 32'(POR_CYC - 1);
      o_busy_flag <= 1'b1;
    end else begin
      case (state)
        CLE_ST_IDLE: begin
          if (go) begin
            state <= CLE_ST_EXEC;
            o_busy_flag <= 1'b1;
            if (cmd == CLE_CMD_CLEAR || cmd == CLE_CMD_HOME) begin
              busy_cnt <= 32'(LONG_CYC - 1);
            end else begin
              busy_cnt <= 32'(SHORT_CYC - 1);
            end
          end
        end
        CLE_ST_EXEC: begin
          if (busy_cnt == 32'h0) begin
            state <= CLE_ST_IDLE;
            o_busy_flag <= 1'b0;
          end else begin
            busy_cnt <= busy_cnt - 32'h1;
          end
        end
        default: begin
          state <= CLE_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg <= `CLE_CFG_RST;
      o_duty <= `CLE_DUTY_8;
    end else if (go) begin
      case (cmd)
        CLE_CMD_CLEAR: begin
          o_cfg.inc <= 1'b1;
        end
        CLE_CMD_ENTRY: begin
          o_cfg.inc <= byte_in[`CLE_B_ID];
          o_cfg.auto_shift <= byte_in[`CLE_B_S];
        end
        CLE_CMD_DISP: begin
          o_cfg.disp_on <= byte_in[`CLE_B_D];
          o_cfg.cursor_on <= byte_in[`CLE_B_C];
          o_cfg.blink_on <= byte_in[`CLE_B_B];
        end
        CLE_CMD_FUNC: begin
          o_cfg.bus8 <= byte_in[`CLE_B_DL];
          o_cfg.two_line <= byte_in[`CLE_B_N];
          o_cfg.font <= byte_in[`CLE_B_F];
          if (byte_in[`CLE_B_N]) begin
            o_duty <= `CLE_DUTY_16;
          end else if (byte_in[`CLE_B_F]) begin
            o_duty <= `CLE_DUTY_11;
          end else begin
            o_duty <= `CLE_DUTY_8;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ac <= 7'h00;
      cg_sel <= 1'b0;
    end else if (go) begin
      ac <= ac_new;
      if (cmd == CLE_CMD_CGADDR) begin
        cg_sel <= 1'b1;
      end else if (cmd == CLE_CMD_DDADDR || cmd == CLE_CMD_CLEAR || cmd == CLE_CMD_HOME) begin
        cg_sel <= 1'b0;
      end
    end
  end

  // One offset serves all lines, so each line rotates in its own range
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ofs <= 7'h00;
    end else if (go) begin
      if (cmd == CLE_CMD_CLEAR || cmd == CLE_CMD_HOME || cmd == CLE_CMD_FUNC) begin
        ofs <= 7'h00;
      end else if ((cmd == CLE_CMD_SHIFT && byte_in[`CLE_B_SC] && !byte_in[`CLE_B_RL]) ||
                   (cmd == CLE_CMD_WRDATA && !cg_sel && o_cfg.auto_shift && o_cfg.inc)) begin
        ofs <= (ofs >= 7'(line_len - 7'h01)) ? 7'h00 : 7'(ofs + 7'h01);
      end else if ((cmd == CLE_CMD_SHIFT && byte_in[`CLE_B_SC]) ||
                   (cmd == CLE_CMD_WRDATA && !cg_sel && o_cfg.auto_shift)) begin
        ofs <= (ofs == 7'h00) ? 7'(line_len - 7'h01) : 7'(ofs - 7'h01);
      end
    end
  end

  // Clear fills one cell a cycle, well inside its busy time
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_on <= 1'b0;
      fill_idx <= 7'h00;
    end else if (go && cmd == CLE_CMD_CLEAR) begin
      fill_on <= 1'b1;
      fill_idx <= 7'h00;
    end else if (fill_on) begin
      fill_on <= (fill_idx != 7'(`CLE_DD_CELLS - 1));
      fill_idx <= 7'(fill_idx + 7'h01);
    end
  end

  generate
    for (genvar g = 0; g < `CLE_DD_CELLS; g++) begin : g_dd
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          dram[g] <= `CLE_SPACE;
        end else if (fill_on && fill_idx == 7'(g)) begin
          dram[g] <= `CLE_SPACE;
        end else if (go && cmd == CLE_CMD_WRDATA && !cg_sel && wr_idx == 7'(g)) begin
          dram[g] <= byte_in;
        end
      end
    end
    for (genvar p = 0; p < `CLE_CG_CELLS; p++) begin : g_cg
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pram[p] <= 8'h00;
        end else if (go && cmd == CLE_CMD_WRDATA && cg_sel && ac[5:0] == 6'(p)) begin
          pram[p] <= byte_in;
        end
      end
    end
  endgenerate

  // Read data come from a prefetch register, so an unprimed first read is stale
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_latch <= 8'h00;
    end else if (go) begin
      if (cmd == CLE_CMD_CGADDR || (cmd == CLE_CMD_RDDATA && cg_sel)) begin
        rd_latch <= pram[ac_new[5:0]];
      end else if (cmd == CLE_CMD_DDADDR || cmd == CLE_CMD_RDDATA ||
                   (cmd == CLE_CMD_SHIFT && !byte_in[`CLE_B_SC])) begin
        rd_latch <= dd_read(dd_idx(ac_new, o_cfg.two_line));
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= 1'b0;
      hold_nib <= 4'h0;
    end else begin
      if (o_cfg.bus8) begin
        phase <= 1'b0;
      end else if (i_wr || i_rd) begin
        phase <= ~phase;
      end
      if (i_wr && !phase) begin
        hold_nib <= i_wdata[7:4];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
      lo_nib <= 4'h0;
    end else if (rd_first) begin
      o_rdata <= o_cfg.bus8 ? rd_word : {rd_word[7:4], 4'h0};
      lo_nib <= rd_word[3:0];
    end else if (i_rd) begin
      o_rdata <= {lo_nib, 4'h0};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blink_cnt <= 32'h0;
      blink_ph <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
      blink_cnt <= 32'h0;
      blink_ph <= ~blink_ph;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // Scan lookup; glyphs from the character ROM lie outside this block
  logic [7:0] scan_sum;
  logic [6:0] cell_idx;
  logic [7:0] cell_code;
  logic [5:0] pat_idx;
  logic at_cursor;
  always_comb begin
    scan_sum = 8'({1'b0, i_scan_col} + {1'b0, ofs});
    if (scan_sum >= {1'b0, line_len}) begin
      scan_sum = 8'(scan_sum - {1'b0, line_len});
    end
    cell_idx = (o_cfg.two_line && i_scan_line) ? 7'(scan_sum[6:0] + `CLE_LINE_LEN) : scan_sum[6:0];
    cell_code = dd_read(cell_idx);
    pat_idx = o_cfg.font ? {cell_code[2:1], i_scan_row} : {cell_code[2:0], i_scan_row[2:0]};
    at_cursor = (cell_idx == wr_idx);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cell <= '0;
    end else begin
      o_cell.code <= cell_code;
      o_cell.from_pattern <= (cell_code[7:4] == 4'h0);
      o_cell.cursor_here <= o_cfg.cursor_on && at_cursor;
      if (!o_cfg.disp_on) begin
        o_cell.pixels <= 5'h00;
      end else if (o_cfg.blink_on && blink_ph && at_cursor) begin
        o_cell.pixels <= 5'h1F;
      end else if (cell_code[7:4] == 4'h0) begin
        o_cell.pixels <= pram[pat_idx][4:0];
      end else begin
        o_cell.pixels <= 5'h00;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_clear_go;
    go && cmd == CLE_CMD_CLEAR;
  endsequence
  sequence s_fill_run;
    fill_on ##79 fill_on ##1 !fill_on;
  endsequence

  a_clear_state: assert property (s_clear_go |=> ac == 7'h00 && o_cfg.inc && !cg_sel)
    else $error("clear left counter or direction wrong");
  a_clear_fill: assert property (s_clear_go |=> s_fill_run)
    else $error("clear fill length wrong");
  a_home_state: assert property (go && cmd == CLE_CMD_HOME |=> ac == 7'h00 && ofs == 7'h00)
    else $error("home did not reset counter and shift");
  a_long_busy: assert property (go && (cmd == CLE_CMD_CLEAR || cmd == CLE_CMD_HOME)
    |=> o_busy_flag && busy_cnt == 32'(LONG_CYC - 1))
    else $error("long busy time wrong");
  a_short_busy: assert property (go && cmd == CLE_CMD_WRDATA |=> o_busy_flag && busy_cnt == 32'(SHORT_CYC - 1))
    else $error("short busy time wrong");
  a_busy_release: assert property (state == CLE_ST_EXEC && busy_cnt == 32'h0 |=> !o_busy_flag ##1 !o_busy_flag)
    else $error("busy did not drop");
  a_step_up: assert property (go && cmd == CLE_CMD_WRDATA && !cg_sel && o_cfg.inc && !o_cfg.two_line
    && ac < `CLE_ONE_LAST |=> ac == 7'($past(ac) + 7'h01))
    else $error("counter did not step up");
  a_line_wrap: assert property (go && cmd == CLE_CMD_WRDATA && !cg_sel && o_cfg.inc && o_cfg.two_line
    && ac == `CLE_L1_LAST |=> ac == `CLE_L2_FIRST)
    else $error("no move to second line");
  a_read_keep: assert property (go && cmd == CLE_CMD_RDDATA |=> ofs == $past(ofs))
    else $error("read shifted the display");
  a_cg_load: assert property (go && cmd == CLE_CMD_CGADDR && byte_in[5:0] == 6'h15 |=> ac == 7'h15 && cg_sel)
    else $error("pattern address not loaded");
  a_dd_load: assert property (go && cmd == CLE_CMD_DDADDR && byte_in[6:0] == 7'h45 |=> ac == 7'h45 && !cg_sel)
    else $error("display address not loaded");
  a_status_word: assert property (rd_first && !i_reg_select && o_cfg.bus8
    |=> o_rdata == {$past(o_busy_flag), $past(ac)})
    else $error("status word wrong");
endmodule
`default_nettype wire

// ### testbench/cle_host_model.sv
/*
  Host processor model for the character display engine bus.
  Assumes strobes sampled on the rising edge of i_clk_sys and read data one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module cle_host_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output logic o_reg_select,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  // Set by the bench after a function set selects the narrow bus
  logic bus4 = 1'b0;
  initial begin
    o_reg_select = 1'b0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // Released data lines show the inverse so stale values never look valid
  task automatic strobe(input logic rs, input logic wr, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_reg_select <= rs;
    o_wr <= wr;
    o_rd <= !wr;
    o_wdata <= d;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic wr(input logic rs, input logic [7:0] d);
    if (bus4) begin
      strobe(rs, 1'b1, {d[7:4], 4'h0});
      strobe(rs, 1'b1, {d[3:0], 4'h0});
    end else begin
      strobe(rs, 1'b1, d);
    end
  endtask
  task automatic rd(input logic rs, output logic [7:0] d);
    strobe(rs, 1'b0, 8'h00);
    #1 d = i_rdata;
    if (bus4) begin
      strobe(rs, 1'b0, 8'h00);
      #1 d = {d[7:4], i_rdata[7:4]};
    end
  endtask
  // Polls status until idle; bounded so a stuck flag cannot hang the run
  task automatic poll(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int k = 0; k < 400 && !ok; k++) begin
      rd(1'b0, s);
      ok = (s[7] === 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
/*
  Self-checking bench for the character display instruction engine.
  Assumes the engine's shortened timing parameters set below.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cle_pkg::*;
  localparam int S = 20;
  localparam int L = 120;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_reg_select, i_wr, i_rd, o_busy_flag, ok;
  logic [7:0] i_wdata, o_rdata, v;
  logic [1:0] o_duty;
  cle_cfg_s o_cfg;
  cle_cell_s o_cell;
  logic i_scan_line = 1'b0;
  logic [6:0] i_scan_col = 7'h00;
  logic [3:0] i_scan_row = 4'h0;
  logic [7:0] fs [4] = '{8'h3C, 8'h34, 8'h30, 8'h38};
  logic [7:0] fd [4] = '{8'h02, 8'h01, 8'h00, 8'h02};
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  always #4 i_clk_sys = ~i_clk_sys;
  cle_host_model cle_host_model_inst (
    .i_clk_sys(i_clk_sys),
    .i_rdata(o_rdata),
    .o_reg_select(i_reg_select),
    .o_wr(i_wr),
    .o_rd(i_rd),
    .o_wdata(i_wdata)
  );
  cle_engine #(.SHORT_CYC(S), .LONG_CYC(L), .POR_CYC(10), .BLINK_CYC(8)) cle_engine_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_reg_select(i_reg_select),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_busy_flag(o_busy_flag),
    .o_cfg(o_cfg),
    .o_duty(o_duty),
    .i_scan_line(i_scan_line),
    .i_scan_col(i_scan_col),
    .i_scan_row(i_scan_row),
    .o_cell(o_cell)
  );
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts busy cycles after an accepted request; a stuck flag ends the run
  task automatic busy_len(output int c);
    c = 0;
    #1;
    while (o_busy_flag === 1'b1) begin
      c++;
      if (c > 400) begin
        n_mismatch++;
        report_and_stop();
      end
      @(posedge i_clk_sys);
      #1;
    end
  endtask
  task automatic ins(input logic [7:0] b, input int t);
    cle_host_model_inst.wr(1'b0, b);
    busy_len(n);
    chk(8'(n), 8'(t));
  endtask
  task automatic dat(input logic [7:0] b);
    cle_host_model_inst.wr(1'b1, b);
    busy_len(n);
    chk(8'(n), 8'(S));
  endtask
  task automatic st(input logic [7:0] exp);
    cle_host_model_inst.rd(1'b0, v);
    chk(v, exp);
  endtask
  task automatic scan(input logic [6:0] col);
    @(posedge i_clk_sys);
    i_scan_col <= col;
    @(posedge i_clk_sys);
    #1;
  endtask
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    cle_host_model_inst.rd(1'b0, v);
    chk({7'h00, v[7]}, 8'h01);
    busy_len(n);
    chk(o_cfg, 8'h82);
    chk({6'h00, o_duty}, 8'h00);
    ins(8'h04, S);
    ins(8'h01, L);
    chk(o_cfg, 8'h82);
    st(8'h00);
    ins(8'h0F, S);
    chk(o_cfg, 8'h9E);
    scan(7'h00);
    n = 0;
    repeat (16) begin
      @(posedge i_clk_sys);
      #1 n += int'(o_cell.pixels === 5'h1F);
    end
    chk({7'h00, n > 0 && n < 16}, 8'h01);
    chk({7'h00, o_cell.cursor_here}, 8'h01);
    ins(8'h0C, S);
    chk(o_cfg, 8'h92);
    scan(7'h00);
    chk({3'h0, o_cell.pixels}, 8'h00);
    chk({7'h00, o_cell.cursor_here}, 8'h00);
    ins(8'h40, S);
    dat(8'h1F);
    st(8'h01);
    ins(8'h80, S);
    dat(8'h08);
    ins(8'h04, S);
    dat(8'h41);
    st(8'h00);
    ins(8'h06, S);
    scan(7'h00);
    chk(o_cell.code, 8'h08);
    chk({2'h0, o_cell.from_pattern, o_cell.pixels}, 8'h3F);
    scan(7'h02);
    chk(o_cell.code, 8'h20);
    ins(8'h80, S);
    cle_host_model_inst.rd(1'b1, v);
    chk(v, 8'h08);
    busy_len(n);
    cle_host_model_inst.rd(1'b1, v);
    chk(v, 8'h41);
    busy_len(n);
    st(8'h02);
    ins(8'h14, S);
    st(8'h03);
    ins(8'h10, S);
    st(8'h02);
    ins(8'h18, S);
    st(8'h02);
    scan(7'h00);
    chk(o_cell.code, 8'h41);
    ins(8'h02, L);
    st(8'h00);
    scan(7'h00);
    chk(o_cell.code, 8'h08);
    cle_host_model_inst.wr(1'b0, 8'h02);
    cle_host_model_inst.wr(1'b0, 8'h85);
    busy_len(n);
    st(8'h00);
    ins(8'h07, S);
    ins(8'h80, S);
    dat(8'h33);
    scan(7'h00);
    chk(o_cell.code, 8'h41);
    ins(8'h06, S);
    for (int k = 0; k < 4; k++) begin
      ins(fs[k], S);
      chk({6'h00, o_duty}, fd[k]);
    end
    ins(8'hA7, S);
    dat(8'h55);
    st(8'h40);
    ins(8'h28, S);
    cle_host_model_inst.bus4 = 1'b1;
    ins(8'h83, S);
    st(8'h03);
    cle_host_model_inst.wr(1'b0, 8'h01);
    cle_host_model_inst.poll(ok);
    chk({7'h00, ok}, 8'h01);
    ins(8'h30, S);
    cle_host_model_inst.bus4 = 1'b0;
    chk(o_cfg, 8'h92);
    st(8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
